// *** rtl/flash_security.sv ***
// Flash and RAM security gate, backdoor key unlock and write-once flash clock divider.
// What this block does
// - Secured access to flash or RAM from unsecured source drops writes, reads zero.
// - Flash and RAM are secure; code fetched from them has full access.
// - Each reset copies the stored option byte into the working option register.
// - Lock code 1 0 alone means unsecured; all other codes engage security.
// - Secured part forbids debug module; background entry only with pin low at reset.
// - Unlock allow bit at zero disables the backdoor key completely.
// - While compare armed, key location writes are compared, not flash commands.
// - Disarm with all eight bytes matching sets lock code 1 0 until reset.
// - Key bytes count only when written by code running from secure memory.
// - The stored key sits in the same 512-byte block as the vectors.
// - Block protect register is written only by background debug accesses.
// - Debug unlock: clear protection, erase, blank check; a blank array unsecures.
// - Ratio register bit 7 is read-only; bits 6..0 take only the first write.
// - Loaded flag clears at reset, sets on first write; gates program and erase.
// - Divider input is bus clock, or bus clock over eight when prescale set.
// - Flash clock is the selected input divided by ratio bits 5..0 plus one.
// - Each timing pulse is one flash clock; operations last whole pulse counts.
// - Working option register reads always, ignores writes, bits 5..2 read zero.
// - Config register bits 7..5 read and write freely; bit 5 arms compare.
`timescale 1ns/1ps
`default_nettype none
module flash_security
  import flash_sec_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Bus access from the CPU or the background debug controller.
  input wire bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  // Memory array side.
  input wire logic [7:0] mem_rdata,
  output logic mem_wr,
  output logic mem_rd,
  // Nonvolatile contents sampled by this block.
  input wire logic [7:0] stored_option_byte,
  input wire logic [7:0] stored_protect_byte,
  input wire logic [63:0] stored_unlock_bytes,
  // Debug mode pin and debug permissions.
  input wire logic debug_mode_pin,
  output logic debug_module_allow,
  output logic active_background_allow,
  // Flash command engine hooks.
  input wire logic blank_check_pass,
  input wire logic pe_start,
  input wire logic [11:0] pe_pulses,
  output logic pe_enabled,
  output logic pe_busy,
  output logic pe_done,
  output logic [7:0] block_protect,
  output logic secured
);
  // Secure memory windows; the stored key lies inside the vector block.
  function automatic logic is_secure_addr(input logic [15:0] a);
    is_secure_addr = (a >= RAM_FIRST && a <= RAM_LAST) ||
                     (a >= FLASH_FIRST && a <= FLASH_LAST);
  endfunction

  function automatic logic is_key_addr(input logic [15:0] a);
    is_key_addr = (a >= KEY_FIRST) && (a < KEY_FIRST + {12'h000, KEY_BYTES}) &&
                  (a >= VECTOR_BLOCK);
  endfunction

  function automatic logic [7:0] key_byte(input logic [63:0] k, input logic [2:0] i);
    key_byte = k[{i, 3'h0} +: 8];
  endfunction

  // Register state.
  logic [7:0] working_option_reg;
  logic [7:0] flash_config_reg;
  logic [7:0] block_protect_reg;
  logic [6:0] ratio_field;
  logic divisor_loaded_flag;
  logic [7:0] next_working_option_reg;
  logic [7:0] next_flash_config_reg;
  logic [7:0] next_block_protect_reg;
  logic [6:0] next_ratio_field;
  logic next_divisor_loaded_flag;
  logic [7:0] next_bus_rdata;

  // Key collection state.
  key_state_t key_state;
  key_state_t next_key_state;
  logic [3:0] key_count;
  logic [3:0] next_key_count;
  logic key_match;
  logic next_key_match;

  // Debug pin synchroniser and reset-time capture.
  logic pin_s1;
  logic pin_s2;
  logic pin_s3;
  logic bg_at_reset;
  logic next_bg_at_reset;

  // Program and erase pulse timer.
  logic [11:0] pulses_left;
  logic [11:0] next_pulses_left;
  logic next_pe_busy;
  logic next_pe_done;
  logic fclk_tick;

  // Access classification.
  logic [1:0] lock_state_code;
  logic backdoor_unlock_allow;
  logic backdoor_compare_arm;
  logic mem_access;
  logic blocked;
  logic key_intercept;
  logic key_write_ok;
  logic disarm;

  assign lock_state_code = working_option_reg[1:0];
  assign backdoor_unlock_allow = working_option_reg[OPTION_ALLOW_BIT];
  assign backdoor_compare_arm = flash_config_reg[CONFIG_ARM_BIT];

  // Security decode and blocking of unsecured sources.
  always_comb begin
    secured = (lock_state_code != CODE_UNSECURED);
    mem_access = is_secure_addr(bus_req.addr);
    blocked = secured && mem_access &&
              (!bus_req.secure_fetch || bus_req.from_debug);
    key_intercept = backdoor_compare_arm && is_key_addr(bus_req.addr);
    key_write_ok = bus_req.wr && key_intercept && backdoor_unlock_allow &&
                   bus_req.secure_fetch && !bus_req.from_debug;
    disarm = bus_req.wr && bus_req.addr == ADDR_CONFIG && backdoor_compare_arm &&
             !bus_req.wdata[CONFIG_ARM_BIT];
  end

  // Memory strobes pass only when not blocked; intercepted key writes never reach flash.
  assign mem_wr = bus_req.wr && mem_access && !blocked && !key_intercept;
  assign mem_rd = bus_req.rd && mem_access && !blocked;

  // Debug permissions follow the security state.
  assign debug_module_allow = !secured;
  assign active_background_allow = !secured || bg_at_reset;
  assign pe_enabled = divisor_loaded_flag;
  assign block_protect = block_protect_reg;

  // Register writes, unlock and read data.
  always_comb begin
    next_working_option_reg = working_option_reg;
    next_flash_config_reg = flash_config_reg;
    next_block_protect_reg = block_protect_reg;
    next_ratio_field = ratio_field;
    next_divisor_loaded_flag = divisor_loaded_flag;
    next_bus_rdata = ZERO_BYTE;
    if (bus_req.wr && bus_req.addr == ADDR_CLK_RATIO && !divisor_loaded_flag) begin
      next_ratio_field = bus_req.wdata[6:0] & RATIO_WR_MASK[6:0];
      next_divisor_loaded_flag = 1'b1;
    end
    if (bus_req.wr && bus_req.addr == ADDR_CONFIG) begin
      next_flash_config_reg = bus_req.wdata & CONFIG_WR_MASK;
    end
    if (bus_req.wr && bus_req.addr == ADDR_PROTECT && bus_req.from_debug) begin
      next_block_protect_reg = bus_req.wdata;
    end
    // A matching key on disarm unlocks; a mismatch changes nothing.
    if (disarm && key_state == KEY_COLLECT && key_count == KEY_BYTES && key_match) begin
      next_working_option_reg[1:0] = CODE_UNSECURED;
    end
    if (blank_check_pass) begin
      next_working_option_reg[1:0] = CODE_UNSECURED;
    end
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        ADDR_CLK_RATIO: begin
          next_bus_rdata = {divisor_loaded_flag, ratio_field};
        end
        ADDR_OPTION: begin
          next_bus_rdata = working_option_reg & OPTION_RD_MASK;
        end
        ADDR_CONFIG: begin
          next_bus_rdata = flash_config_reg;
        end
        ADDR_PROTECT: begin
          next_bus_rdata = block_protect_reg;
        end
        default: begin
          next_bus_rdata = (mem_access && !blocked) ? mem_rdata : ZERO_BYTE;
        end
      endcase
    end
  end

  // The option byte is reloaded on every reset cycle, so it tracks the stored copy.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      working_option_reg <= stored_option_byte & OPTION_RD_MASK;
      block_protect_reg <= stored_protect_byte;
      flash_config_reg <= CONFIG_RESET;
      ratio_field <= RATIO_RESET[6:0];
      divisor_loaded_flag <= RATIO_RESET[RATIO_LOADED_BIT];
      bus_rdata <= ZERO_BYTE;
    end else begin
      working_option_reg <= next_working_option_reg;
      block_protect_reg <= next_block_protect_reg;
      flash_config_reg <= next_flash_config_reg;
      ratio_field <= next_ratio_field;
      divisor_loaded_flag <= next_divisor_loaded_flag;
      bus_rdata <= next_bus_rdata;
    end
  end

  // Key collection: bytes must land in ascending order; any stray write to a key location spoils the match.
  always_comb begin
    next_key_state = key_state;
    next_key_count = key_count;
    next_key_match = key_match;
    unique case (key_state)
      KEY_OFF: begin
        if (bus_req.wr && bus_req.addr == ADDR_CONFIG && bus_req.wdata[CONFIG_ARM_BIT] &&
            backdoor_unlock_allow) begin
          next_key_state = KEY_COLLECT;
          next_key_count = 4'h0;
          next_key_match = 1'b1;
        end
      end
      KEY_COLLECT: begin
        if (key_write_ok) begin
          // Order is enforced by requiring the address to match the running index.
          if (key_count < KEY_BYTES &&
              bus_req.addr == KEY_FIRST + {12'h000, key_count} &&
              bus_req.wdata == key_byte(stored_unlock_bytes, key_count[2:0])) begin
            next_key_count = key_count + 4'h1;
          end else begin
            next_key_match = 1'b0;
          end
        end else if (bus_req.wr && key_intercept) begin
          next_key_match = 1'b0;
        end
        if (disarm || !backdoor_unlock_allow) begin
          next_key_state = KEY_OFF;
          next_key_match = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      key_state <= KEY_OFF;
      key_count <= 4'h0;
      key_match <= 1'b0;
    end else begin
      key_state <= next_key_state;
      key_count <= next_key_count;
      key_match <= next_key_match;
    end
  end

  // Background entry is decided by the last agreed pin level seen while reset is held.
  always_comb begin
    next_bg_at_reset = bg_at_reset;
    if (rst && pin_s2 == pin_s3) begin
      next_bg_at_reset = !pin_s3;
    end
  end

  // The synchroniser runs through reset so the pin is seen at the release (falling edge) of reset.
  always_ff @(posedge core_clk) begin
    pin_s1 <= debug_mode_pin;
    pin_s2 <= pin_s1;
    pin_s3 <= pin_s2;
    bg_at_reset <= next_bg_at_reset;
  end

  // Flash clock generation; stopped until the ratio register has been written.
  flash_clk_divider u_div (
    .core_clk(core_clk),
    .rst(rst),
    .enable(divisor_loaded_flag),
    .prescale_by_eight(ratio_field[RATIO_PRESCALE_BIT]),
    .ratio(ratio_field[5:0]),
    .fclk_tick(fclk_tick)
  );

  // Pulse timer: an operation lasts a whole number of flash clock pulses.
  always_comb begin
    next_pulses_left = pulses_left;
    next_pe_busy = pe_busy;
    next_pe_done = 1'b0;
    if (!pe_busy) begin
      if (pe_start && divisor_loaded_flag && pe_pulses != 12'h000) begin
        next_pulses_left = pe_pulses;
        next_pe_busy = 1'b1;
      end
    end else if (fclk_tick) begin
      next_pulses_left = pulses_left - 12'h001;
      if (pulses_left == 12'h001) begin
        next_pe_busy = 1'b0;
        next_pe_done = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pulses_left <= 12'h000;
      pe_busy <= 1'b0;
      pe_done <= 1'b0;
    end else begin
      pulses_left <= next_pulses_left;
      pe_busy <= next_pe_busy;
      pe_done <= next_pe_done;
    end
  end
endmodule
`default_nettype wire

// *** pkg/flash_sec_pkg.sv ***
// Shared constants and carrier types for flash security and the flash clock divider.
package flash_sec_pkg;
  // High-page register addresses.
  localparam logic [15:0] ADDR_CLK_RATIO = 16'h1820;
  localparam logic [15:0] ADDR_OPTION = 16'h1821;
  localparam logic [15:0] ADDR_CONFIG = 16'h1823;
  localparam logic [15:0] ADDR_PROTECT = 16'h1824;
  // Secure memory windows and the stored unlock key.
  localparam logic [15:0] RAM_FIRST = 16'h0080;
  localparam logic [15:0] RAM_LAST = 16'h087F;
  localparam logic [15:0] FLASH_FIRST = 16'hC000;
  localparam logic [15:0] FLASH_LAST = 16'hFFFF;
  localparam logic [15:0] KEY_FIRST = 16'hFFB0;
  localparam logic [15:0] VECTOR_BLOCK = 16'hFE00;
  localparam logic [3:0] KEY_BYTES = 4'h8;
  localparam logic [2:0] KEY_LAST_IDX = 3'h7;
  // Field positions and masks.
  localparam int RATIO_LOADED_BIT = 7;
  localparam int RATIO_PRESCALE_BIT = 6;
  localparam logic [7:0] RATIO_WR_MASK = 8'h7F;
  localparam logic [7:0] OPTION_RD_MASK = 8'hC3;
  localparam int OPTION_ALLOW_BIT = 7;
  localparam logic [7:0] CONFIG_WR_MASK = 8'hE0;
  localparam int CONFIG_ARM_BIT = 5;
  localparam logic [1:0] CODE_UNSECURED = 2'h2;
  // Reset values.
  localparam logic [7:0] RATIO_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // Divider and pulse timer widths.
  localparam logic [2:0] PRESCALE_LAST = 3'h7;
  localparam int PULSE_CNT_W = 12;
  // One CPU or debug bus access.
  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
    logic secure_fetch;
    logic from_debug;
  } bus_req_t;
  // Key collection progress.
  typedef enum logic [0:0] {KEY_OFF, KEY_COLLECT} key_state_t;
endpackage

// *** rtl/flash_clk_divider.sv ***
// Flash clock divider producing one-cycle ticks at the internal flash clock rate.
`timescale 1ns/1ps
`default_nettype none
module flash_clk_divider
  import flash_sec_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Divider setup.
  input wire logic enable,
  input wire logic prescale_by_eight,
  input wire logic [5:0] ratio,
  // Flash clock tick.
  output logic fclk_tick
);
  logic [2:0] pre_cnt;
  logic [5:0] div_cnt;
  logic [2:0] next_pre_cnt;
  logic [5:0] next_div_cnt;
  logic pre_tick;
  logic next_fclk_tick;

  // Prescale stage feeds a ratio+1 stage; the tick marks one flash clock cycle.
  always_comb begin
    pre_tick = enable && (!prescale_by_eight || pre_cnt == PRESCALE_LAST);
    next_pre_cnt = (!enable || !prescale_by_eight) ? 3'h0 : pre_cnt + 3'h1;
    next_div_cnt = div_cnt;
    next_fclk_tick = 1'b0;
    if (!enable) begin
      next_div_cnt = 6'h00;
    end else if (pre_tick) begin
      if (div_cnt >= ratio) begin
        next_div_cnt = 6'h00;
        next_fclk_tick = 1'b1;
      end else begin
        next_div_cnt = div_cnt + 6'h01;
      end
    end
  end

  // Registers only.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pre_cnt <= 3'h0;
      div_cnt <= 6'h00;
      fclk_tick <= 1'b0;
    end else begin
      pre_cnt <= next_pre_cnt;
      div_cnt <= next_div_cnt;
      fclk_tick <= next_fclk_tick;
    end
  end
endmodule
`default_nettype wire

// *** verification/flash_array_model.sv ***
// Behavioural memory array standing behind the security gate.
`timescale 1ns/1ps
`default_nettype none
module flash_array_model
  import flash_sec_pkg::*;
(
  // Clock.
  input wire logic core_clk,
  // Array read request from the gate.
  input wire logic [15:0] addr,
  input wire logic mem_rd,
  // Array read data.
  output logic [7:0] mem_rdata
);
  logic [7:0] churn = 8'h5A;
  // Idle data lines keep changing, so stale data can never pass for an answer.
  always @(posedge core_clk) begin
    churn <= {churn[6:0], churn[7]} ^ 8'h1D;
  end
  // Contents are a fixed address hash; a read answers within its own cycle.
  assign mem_rdata = mem_rd ? (addr[7:0] ^ addr[15:8] ^ 8'h3C) : churn;
endmodule
`default_nettype wire

// *** verification/flash_security_props.sv ***
// Assertion checker for the flash security block, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module flash_security_props
  import flash_sec_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Watched ports.
  input wire bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic debug_module_allow,
  input wire logic blank_check_pass,
  input wire logic pe_start,
  input wire logic pe_enabled,
  input wire logic pe_busy,
  input wire logic pe_done,
  input wire logic [7:0] block_protect,
  input wire logic secured
);
  logic in_mem;
  logic shut;
  // Secure window hit, and whether the requester is barred from it.
  assign in_mem = (bus_req.addr >= RAM_FIRST && bus_req.addr <= RAM_LAST) ||
                  bus_req.addr >= FLASH_FIRST;
  assign shut = secured && in_mem && (!bus_req.secure_fetch || bus_req.from_debug);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  blocked_read_a:
  assert property (bus_req.rd && shut |-> !mem_rd ##1 bus_rdata == ZERO_BYTE)
    else $error("blocked read reached the array");
  blocked_write_a:
  assert property (bus_req.wr && shut |-> !mem_wr) else $error("blocked write reached the array");
  trusted_read_a:
  assert property (bus_req.rd && in_mem && !shut |-> mem_rd ##1 bus_rdata == $past(mem_rdata))
    else $error("trusted read did not return array data");
  debug_allow_a:
  assert property (debug_module_allow == !secured) else $error("debug module allowed while secured");
  loaded_cause_a:
  assert property ($rose(pe_enabled) |-> $past(bus_req.wr) && $past(bus_req.addr) == ADDR_CLK_RATIO)
    else $error("loaded flag set without a ratio write");
  pe_refuse_a:
  assert property (pe_start && !pe_enabled && !pe_busy |=> !pe_busy)
    else $error("timer started before divisor loaded");
  pe_done_a:
  assert property (pe_done |-> !pe_busy && $past(pe_busy)) else $error("done pulse out of place");
  protect_cpu_a:
  assert property (bus_req.wr && bus_req.addr == ADDR_PROTECT && !bus_req.from_debug
    |=> $stable(block_protect)) else $error("software changed block protect");
  protect_debug_a:
  assert property (bus_req.wr && bus_req.addr == ADDR_PROTECT && bus_req.from_debug
    |=> block_protect == $past(bus_req.wdata)) else $error("debug protect write lost");
  blank_unlock_a:
  assert property (blank_check_pass |=> !secured) else $error("blank check left part secured");
endmodule
`default_nettype wire
bind flash_security flash_security_props u_props (.core_clk(core_clk), .rst(rst),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .mem_rdata(mem_rdata), .mem_rd(mem_rd),
  .mem_wr(mem_wr), .debug_module_allow(debug_module_allow),
  .blank_check_pass(blank_check_pass), .pe_start(pe_start), .pe_enabled(pe_enabled),
  .pe_busy(pe_busy), .pe_done(pe_done), .block_protect(block_protect), .secured(secured));

// *** verification/tb_flash_security.sv ***
// Self-checking testbench for the flash security block.
`timescale 1ns/1ps
`default_nettype none
module tb_flash_security;
  import flash_sec_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  bus_req_t bus_req = '0;
  logic [7:0] bus_rdata, mem_rdata, block_protect, rd_val, d;
  logic [7:0] opt = 8'hC3;
  logic [7:0] prot = 8'h00;
  logic [63:0] key = 64'h0;
  logic pin = 1'b1;
  logic blank = 1'b0;
  logic pe_start = 1'b0;
  logic [11:0] pe_pulses = 12'h000;
  logic mem_wr, mem_rd, dbg_allow, bg_allow, pe_enabled, pe_busy, pe_done, secured, wr_seen;
  logic [15:0] a;
  int n_fail = 0;
  int n_tests = 0;
  int seed = 32'h2084FB89;
  int cnt, per, n;
  // The clock toggles every half period of 5 ns.
  always #5 core_clk = ~core_clk;
  flash_security DUT (.core_clk(core_clk), .rst(rst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_rd(mem_rd),
    .stored_option_byte(opt), .stored_protect_byte(prot), .stored_unlock_bytes(key),
    .debug_mode_pin(pin), .debug_module_allow(dbg_allow), .active_background_allow(bg_allow),
    .blank_check_pass(blank), .pe_start(pe_start), .pe_pulses(pe_pulses),
    .pe_enabled(pe_enabled), .pe_busy(pe_busy), .pe_done(pe_done),
    .block_protect(block_protect), .secured(secured));
  flash_array_model u_array (.core_clk(core_clk), .addr(bus_req.addr), .mem_rd(mem_rd),
    .mem_rdata(mem_rdata));
  // Expected array contents, an address hash independent of the model's code.
  function automatic logic [7:0] exp_mem(input logic [15:0] x);
    return x[15:8] ^ x[7:0] ^ 8'h3C;
  endfunction
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One access held for one cycle; the registered read data is taken after release.
  task automatic acc(input logic [15:0] ad, input logic r, input logic [7:0] wd,
                     input logic sf, input logic dbg);
    @(posedge core_clk) #1;
    bus_req = '{addr: ad, rd: r, wr: !r, wdata: wd, secure_fetch: sf, from_debug: dbg};
    #1 wr_seen = mem_wr;
    @(posedge core_clk) #1;
    bus_req = '0;
    rd_val = bus_rdata;
  endtask
  task automatic do_reset(input logic [7:0] o, input logic p);
    @(posedge core_clk) #1;
    rst = 1'b1;
    opt = o;
    pin = p;
    repeat (16) @(posedge core_clk);
    #1 rst = 1'b0;
    chk("secured", 8'(secured), 8'(o[1:0] != CODE_UNSECURED));
    chk("bg allow", 8'(bg_allow), 8'(o[1:0] == CODE_UNSECURED || !p));
    chk("dbg allow", 8'(dbg_allow), 8'(o[1:0] == CODE_UNSECURED));
    acc(ADDR_OPTION, 1'b0, ~o, 1'b1, 1'b1);
    acc(ADDR_OPTION, 1'b1, 8'h00, 1'b1, 1'b0);
    chk("option", rd_val, o & OPTION_RD_MASK);
  endtask
  // Arming, eight spaced key writes in ascending order, then disarming.
  task automatic enter_key(input logic [63:0] k, input logic dbg);
    acc(ADDR_CONFIG, 1'b0, 8'hFF, 1'b1, 1'b0);
    acc(ADDR_CONFIG, 1'b1, 8'h00, 1'b1, 1'b0);
    chk("config", rd_val, CONFIG_WR_MASK);
    for (int i = 0; i < 8; i++) begin
      acc(KEY_FIRST + 16'(i), 1'b0, k[8*i +: 8], !dbg, dbg);
      chk("key mem_wr", 8'(wr_seen), 8'h00);
    end
    acc(ADDR_CONFIG, 1'b0, 8'h00, 1'b1, 1'b0);
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // The run needs a few thousand cycles; twenty thousand cycles means a hang.
  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end
  initial begin
    prot = 8'($random(seed));
    key = {$random(seed), $random(seed)};
    for (int c = 0; c < 4; c++) begin
      do_reset({6'h3F, 2'(c)}, c[0]);
    end
    $display("lock code test done");
    for (int j = 0; j < 12; j++) begin
      a = 16'($random(seed));
      a = j[0] ? (FLASH_FIRST | (a & 16'h0FFF)) : (RAM_FIRST + (a & 16'h07FF));
      acc(a, 1'b1, 8'h00, j % 3 != 0, j % 3 == 1);
      chk("mem read", rd_val, (j % 3 == 2) ? exp_mem(a) : ZERO_BYTE);
      acc(a, 1'b0, 8'h00, j % 3 != 0, j % 3 == 1);
      chk("mem write", 8'(wr_seen), 8'(j % 3 == 2));
    end
    $display("gate test done");
    chk("ratio reset", 8'(pe_enabled), 8'h00);
    // A start before the divisor is loaded must be refused.
    @(posedge core_clk) #1;
    pe_start = 1'b1;
    pe_pulses = 12'h001;
    @(posedge core_clk) #1;
    pe_start = 1'b0;
    chk("refused start", 8'(pe_busy), 8'h00);
    // Prescale by eight with ratio 62 or 63 keeps the flash clock near 196 kHz at 100 MHz.
    d = {2'h1, 5'h1F, 1'($random(seed))};
    acc(ADDR_CLK_RATIO, 1'b0, d, 1'b0, 1'b0);
    acc(ADDR_CLK_RATIO, 1'b0, ~d, 1'b1, 1'b0);
    acc(ADDR_CLK_RATIO, 1'b1, 8'h00, 1'b0, 1'b0);
    chk("ratio", rd_val, d | 8'h80);
    per = (d[6] ? 8 : 1) * (d[5:0] + 1);
    n = 2 + ($unsigned($random(seed)) % 3);
    @(posedge core_clk) #1;
    pe_start = 1'b1;
    pe_pulses = 12'(n);
    @(posedge core_clk) #1;
    pe_start = 1'b0;
    chk("busy", 8'(pe_busy), 8'h01);
    cnt = 0;
    while (pe_done !== 1'b1 && cnt < 3000) begin
      @(posedge core_clk) #1;
      cnt++;
    end
    chk("pulse span", 8'(cnt >= (n - 1) * per && cnt <= n * per + 2), 8'h01);
    $display("divider test done");
    acc(ADDR_PROTECT, 1'b0, ~prot, 1'b1, 1'b0);
    chk("protect cpu", block_protect, prot);
    acc(ADDR_PROTECT, 1'b0, 8'h5A, 1'b0, 1'b1);
    chk("protect dbg", block_protect, 8'h5A);
    $display("protect test done");
    do_reset(8'h80, 1'b1);
    enter_key(key ^ (64'h1 << ($unsigned($random(seed)) % 64)), 1'b0);
    chk("bad key", 8'(secured), 8'h01);
    enter_key(key, 1'b1);
    chk("debug key", 8'(secured), 8'h01);
    enter_key(key, 1'b0);
    chk("good key", 8'(secured), 8'h00);
    acc(FLASH_FIRST, 1'b1, 8'h00, 1'b0, 1'b1);
    chk("open read", rd_val, exp_mem(FLASH_FIRST));
    do_reset(8'h00, 1'b0);
    enter_key(key, 1'b0);
    chk("key barred", 8'(secured), 8'h01);
    @(posedge core_clk) #1;
    blank = 1'b1;
    @(posedge core_clk) #1;
    blank = 1'b0;
    chk("blank unlock", 8'(secured), 8'h00);
    $display("unlock test done");
    give_verdict();
  end
endmodule
`default_nettype wire
